// >>> crf_core_regs.sv
`timescale 1ns/1ps

// Operation
// - Word or either byte of registers accessible
// - Address use always takes full sixteen bits
// - Register seven serves as stack pointer
// - Instruction pointer sixteen bits, low bit zero
// - Mask bit blocks all but non-maskable interrupt
// - Mask set on reset and interrupt entry
// - Two user bits freely read and written
// - Byte arithmetic half-carry from bit three
// - Word arithmetic half-carry from bit eleven
// - Negative flag copies result sign bit
// - Zero flag set exactly on zero result
// - Overflow flag set only on arithmetic overflow
// - Carry records add/subtract carry or borrow
// - Carry captures bit shifted out
// - Carry acts as bit accumulator
// - Flags loadable, storable, and/or/xor maskable
// - Branch conditions from N, Z, V, C
// - Reset loads pointer from vector, sets mask
// - Other flags and registers not meaningfully initialised
// - Word addresses force bit zero low
// - Stack words only; flags pushed doubled
// - Decimal adjust treats nibbles as BCD digits
module crf_core_regs (
    input  wire logic                   CLK,
    input  wire logic                   RST,
    input  wire crf_pkg::crf_reg_wr_s   REG_WR,
    input  wire crf_pkg::crf_reg_rd_s   REG_RD,
    input  wire logic [2:0]             ADDR_SEL,
    input  wire crf_pkg::crf_flag_req_s FLAG_REQ,
    input  wire crf_pkg::crf_stk_req_s  STK_REQ,
    input  wire logic [15:0]            STK_RDATA,
    input  wire crf_pkg::crf_nip_req_s  NIP_REQ,
    input  wire logic                   IRQ_PEND,
    input  wire logic                   NMI_PEND,
    input  wire logic                   INT_ENTRY,
    input  wire logic [15:0]            VEC_DATA,
    input  wire logic                   VEC_VALID,
    output logic [15:0]                 REG_RDATA,
    output logic [15:0]                 ADDR_FULL,
    output logic [15:0]                 ADDR_WORD,
    output logic [15:0]                 STACK_PTR,
    output crf_pkg::crf_stk_bus_s       STK_BUS,
    output logic [15:0]                 POP_DATA,
    output logic [15:0]                 NIP_OUT,
    output logic [7:0]                  FLAGS_OUT,
    output logic [15:0]                 RESULT_OUT,
    output logic                        BRANCH_TAKEN,
    output logic                        INT_ACCEPT,
    output logic [15:0]                 VEC_ADDR,
    output logic                        VEC_REQ,
    output logic                        CORE_READY
);

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] align_word(input logic [15:0] addr);
        align_word = {addr[15:1], 1'b0};
    endfunction

    function automatic logic cond_eval(input crf_pkg::crf_cond_e cc, input logic [7:0] f);
        logic n;
        logic z;
        logic v;
        logic c;
        n = f[crf_pkg::FLAG_N];
        z = f[crf_pkg::FLAG_Z];
        v = f[crf_pkg::FLAG_V];
        c = f[crf_pkg::FLAG_C];
        case (cc)
            crf_pkg::COND_ALWAYS: cond_eval = 1'b1;
            crf_pkg::COND_NEVER:  cond_eval = 1'b0;
            crf_pkg::COND_HI:     cond_eval = !(c | z);
            crf_pkg::COND_LS:     cond_eval = c | z;
            crf_pkg::COND_CC:     cond_eval = !c;
            crf_pkg::COND_CS:     cond_eval = c;
            crf_pkg::COND_NE:     cond_eval = !z;
            crf_pkg::COND_EQ:     cond_eval = z;
            crf_pkg::COND_VC:     cond_eval = !v;
            crf_pkg::COND_VS:     cond_eval = v;
            crf_pkg::COND_PL:     cond_eval = !n;
            crf_pkg::COND_MI:     cond_eval = n;
            crf_pkg::COND_GE:     cond_eval = !(n ^ v);
            crf_pkg::COND_LT:     cond_eval = n ^ v;
            crf_pkg::COND_GT:     cond_eval = !(z | (n ^ v));
            default:              cond_eval = z | (n ^ v);
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    logic [15:0]           regs_ff [8];
    logic [15:0]           nxt_regs [8];
    logic [7:0]            flags_ff;
    logic [7:0]            nxt_flags;
    logic [15:0]           nip_ff;
    logic [15:0]           result_ff;
    logic [15:0]           rdata_ff;
    logic [15:0]           addr_full_ff;
    logic [15:0]           addr_word_ff;
    logic [15:0]           pop_data_ff;
    logic                  branch_ff;
    logic                  int_accept_ff;
    crf_pkg::crf_stk_bus_s stk_bus_ff;
    crf_pkg::crf_state_e   state_ff;
    logic                  running;
    logic                  stk_push;
    logic                  stk_pop;

    assign running  = (state_ff == crf_pkg::ST_RUN);
    assign stk_push = (STK_REQ.op == crf_pkg::STK_PUSH_WORD) ||
                      (STK_REQ.op == crf_pkg::STK_PUSH_FLAGS);
    assign stk_pop  = (STK_REQ.op == crf_pkg::STK_POP_WORD) ||
                      (STK_REQ.op == crf_pkg::STK_POP_FLAGS);

    ////////////////////////////////////////////////////////////////////////////
    // General registers; stack adjustment of register seven beats a port write
    for (genvar gi = 0; gi < 8; gi++) begin : g_reg
        always_comb begin
            nxt_regs[gi] = regs_ff[gi];
            if (REG_WR.we && REG_WR.sel == 3'(gi)) begin
                if (REG_WR.word) begin
                    nxt_regs[gi] = REG_WR.data;
                end else if (REG_WR.high) begin
                    nxt_regs[gi][15:8] = REG_WR.data[7:0];
                end else begin
                    nxt_regs[gi][7:0] = REG_WR.data[7:0];
                end
            end
            if (3'(gi) == crf_pkg::STACK_REG_IDX && stk_push) begin
                nxt_regs[gi] = 16'(align_word(regs_ff[gi]) - crf_pkg::WORD_STEP);
            end else if (3'(gi) == crf_pkg::STACK_REG_IDX && stk_pop) begin
                nxt_regs[gi] = 16'(align_word(regs_ff[gi]) + crf_pkg::WORD_STEP);
            end
        end

        always_ff @(posedge CLK) begin
            if (RST) begin
                regs_ff[gi] <= crf_pkg::REGS_RESET;
            end else begin
                regs_ff[gi] <= nxt_regs[gi];
            end
        end
    end

    // Byte reads come back zero-extended; address reads are always full words
    always_ff @(posedge CLK) begin
        if (RST) begin
            rdata_ff     <= 16'h0000;
            addr_full_ff <= 16'h0000;
            addr_word_ff <= 16'h0000;
        end else begin
            if (REG_RD.word) begin
                rdata_ff <= regs_ff[REG_RD.sel];
            end else if (REG_RD.high) begin
                rdata_ff <= {8'h00, regs_ff[REG_RD.sel][15:8]};
            end else begin
                rdata_ff <= {8'h00, regs_ff[REG_RD.sel][7:0]};
            end
            addr_full_ff <= regs_ff[ADDR_SEL];
            addr_word_ff <= align_word(regs_ff[ADDR_SEL]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Stack port: address always tracks the aligned top of stack
    always_ff @(posedge CLK) begin
        if (RST) begin
            stk_bus_ff  <= '0;
            pop_data_ff <= 16'h0000;
        end else begin
            stk_bus_ff.addr <= align_word(nxt_regs[crf_pkg::STACK_REG_IDX]);
            stk_bus_ff.we   <= stk_push;
            if (STK_REQ.op == crf_pkg::STK_PUSH_FLAGS) begin
                stk_bus_ff.wdata <= {flags_ff, flags_ff};
            end else if (STK_REQ.op == crf_pkg::STK_PUSH_WORD) begin
                stk_bus_ff.wdata <= STK_REQ.wdata;
            end
            if (STK_REQ.op == crf_pkg::STK_POP_WORD) begin
                pop_data_ff <= STK_RDATA;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flag engine
    logic        sub_op;
    logic        cin;
    logic [15:0] opa;
    logic [15:0] opb;
    logic [16:0] w_ext;
    logic [8:0]  b_ext;
    logic [15:0] ar_res;
    logic [15:0] x_w;
    logic [8:0]  x_b;
    logic        sa;
    logic        sb;
    logic        sr;
    logic        lo_big;
    logic        hi_big;
    logic        adj_lo;
    logic        adj_hi;
    logic [7:0]  adj;
    logic [7:0]  dec_res;
    logic [15:0] nxt_result;
    logic [7:0]  eng_flags;

    always_comb begin
        sub_op = (FLAG_REQ.op == crf_pkg::FOP_SUB) || (FLAG_REQ.op == crf_pkg::FOP_SUBX) ||
                 (FLAG_REQ.op == crf_pkg::FOP_CMP) || (FLAG_REQ.op == crf_pkg::FOP_NEG);
        cin    = ((FLAG_REQ.op == crf_pkg::FOP_ADDX) || (FLAG_REQ.op == crf_pkg::FOP_SUBX)) &&
                 flags_ff[crf_pkg::FLAG_C];
        opa    = (FLAG_REQ.op == crf_pkg::FOP_NEG) ? 16'h0000 : FLAG_REQ.a;
        opb    = (FLAG_REQ.op == crf_pkg::FOP_NEG) ? FLAG_REQ.a : FLAG_REQ.b;
        if (sub_op) begin
            w_ext = {1'b0, opa} - {1'b0, opb} - {16'h0000, cin};
            b_ext = {1'b0, opa[7:0]} - {1'b0, opb[7:0]} - {8'h00, cin};
        end else begin
            w_ext = {1'b0, opa} + {1'b0, opb} + {16'h0000, cin};
            b_ext = {1'b0, opa[7:0]} + {1'b0, opb[7:0]} + {8'h00, cin};
        end
        // Carry into a bit is a ^ b ^ sum for both add and subtract
        x_w    = opa ^ opb ^ w_ext[15:0];
        x_b    = {1'b0, opa[7:0] ^ opb[7:0] ^ b_ext[7:0]};
        ar_res = FLAG_REQ.word ? w_ext[15:0] : {8'h00, b_ext[7:0]};
        sa     = FLAG_REQ.word ? opa[15] : opa[7];
        sb     = FLAG_REQ.word ? opb[15] : opb[7];
        sr     = FLAG_REQ.word ? ar_res[15] : ar_res[7];
        // Packed BCD correction, one decimal digit per nibble
        lo_big  = FLAG_REQ.a[3:0] > crf_pkg::NIBBLE_MAX;
        hi_big  = (FLAG_REQ.a[7:4] > crf_pkg::NIBBLE_MAX) ||
                  ((FLAG_REQ.a[7:4] == crf_pkg::NIBBLE_MAX) && lo_big);
        if (FLAG_REQ.op == crf_pkg::FOP_DEC_ADD) begin
            adj_lo = flags_ff[crf_pkg::FLAG_H] || lo_big;
            adj_hi = flags_ff[crf_pkg::FLAG_C] || hi_big;
        end else begin
            adj_lo = flags_ff[crf_pkg::FLAG_H];
            adj_hi = flags_ff[crf_pkg::FLAG_C];
        end
        adj     = {(adj_hi ? crf_pkg::DEC_ADJ : 4'h0), (adj_lo ? crf_pkg::DEC_ADJ : 4'h0)};
        dec_res = (FLAG_REQ.op == crf_pkg::FOP_DEC_ADD) ? 8'(FLAG_REQ.a[7:0] + adj) :
                                                           8'(FLAG_REQ.a[7:0] - adj);
        nxt_result = result_ff;
        eng_flags  = flags_ff;
        case (FLAG_REQ.op)
            crf_pkg::FOP_ADD, crf_pkg::FOP_ADDX, crf_pkg::FOP_SUB, crf_pkg::FOP_SUBX,
            crf_pkg::FOP_CMP, crf_pkg::FOP_NEG: begin
                nxt_result                 = ar_res;
                eng_flags[crf_pkg::FLAG_H] = FLAG_REQ.word ? x_w[12] : x_b[4];
                eng_flags[crf_pkg::FLAG_N] = sr;
                eng_flags[crf_pkg::FLAG_Z] = FLAG_REQ.word ? (ar_res == 16'h0000) :
                                                             (ar_res[7:0] == 8'h00);
                eng_flags[crf_pkg::FLAG_V] = sub_op ? ((sa != sb) && (sr != sa)) :
                                                      ((sa == sb) && (sr != sa));
                eng_flags[crf_pkg::FLAG_C] = FLAG_REQ.word ? w_ext[16] : b_ext[8];
            end
            crf_pkg::FOP_LOGIC, crf_pkg::FOP_SHIFT: begin
                nxt_result                 = FLAG_REQ.a;
                eng_flags[crf_pkg::FLAG_N] = FLAG_REQ.word ? FLAG_REQ.a[15] : FLAG_REQ.a[7];
                eng_flags[crf_pkg::FLAG_Z] = FLAG_REQ.word ? (FLAG_REQ.a == 16'h0000) :
                                                             (FLAG_REQ.a[7:0] == 8'h00);
                eng_flags[crf_pkg::FLAG_V] = 1'b0;
                if (FLAG_REQ.op == crf_pkg::FOP_SHIFT) begin
                    eng_flags[crf_pkg::FLAG_C] = FLAG_REQ.bit_in;
                end
            end
            crf_pkg::FOP_BIT_ACC: begin
                eng_flags[crf_pkg::FLAG_C] = FLAG_REQ.bit_in;
            end
            crf_pkg::FOP_LOAD_FLAGS: eng_flags = FLAG_REQ.b[7:0];
            crf_pkg::FOP_AND_FLAGS:  eng_flags = flags_ff & FLAG_REQ.b[7:0];
            crf_pkg::FOP_OR_FLAGS:   eng_flags = flags_ff | FLAG_REQ.b[7:0];
            crf_pkg::FOP_XOR_FLAGS:  eng_flags = flags_ff ^ FLAG_REQ.b[7:0];
            crf_pkg::FOP_DEC_ADD, crf_pkg::FOP_DEC_SUB: begin
                nxt_result                 = {8'h00, dec_res};
                eng_flags[crf_pkg::FLAG_N] = dec_res[7];
                eng_flags[crf_pkg::FLAG_Z] = (dec_res == 8'h00);
                eng_flags[crf_pkg::FLAG_C] = adj_hi;
            end
            default: begin
                nxt_result = result_ff;
            end
        endcase
    end

    // Pop beats the engine, and interrupt entry always leaves the mask set
    always_comb begin
        nxt_flags = eng_flags;
        if (STK_REQ.op == crf_pkg::STK_POP_FLAGS) begin
            nxt_flags = STK_RDATA[15:8];
        end
        if (INT_ENTRY) begin
            nxt_flags[crf_pkg::FLAG_I] = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            flags_ff  <= crf_pkg::FLAGS_RESET;
            result_ff <= 16'h0000;
        end else begin
            flags_ff  <= nxt_flags;
            result_ff <= nxt_result;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt gate: the mask holds off everything but the non-maskable line
    always_ff @(posedge CLK) begin
        if (RST) begin
            int_accept_ff <= 1'b0;
        end else begin
            int_accept_ff <= running && (NMI_PEND ||
                             (IRQ_PEND && !flags_ff[crf_pkg::FLAG_I]));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Start-up: fetch the reset vector, then run
    always_ff @(posedge CLK) begin
        if (RST) begin
            state_ff <= crf_pkg::ST_FETCH_VEC;
        end else begin
            case (state_ff)
                crf_pkg::ST_FETCH_VEC: begin
                    if (VEC_VALID) begin
                        state_ff <= crf_pkg::ST_RUN;
                    end
                end
                crf_pkg::ST_RUN: state_ff <= crf_pkg::ST_RUN;
                default:         state_ff <= crf_pkg::ST_FETCH_VEC;
            endcase
        end
    end

    // Instruction pointer; requests are ignored until the vector has arrived
    always_ff @(posedge CLK) begin
        if (RST) begin
            nip_ff    <= crf_pkg::NIP_RESET;
            branch_ff <= 1'b0;
        end else begin
            branch_ff <= 1'b0;
            if (!running) begin
                if (VEC_VALID) begin
                    nip_ff <= align_word(VEC_DATA);
                end
            end else begin
                case (NIP_REQ.op)
                    crf_pkg::NOP_ADVANCE: nip_ff <= 16'(nip_ff + crf_pkg::WORD_STEP);
                    crf_pkg::NOP_JUMP:    nip_ff <= align_word(NIP_REQ.target);
                    crf_pkg::NOP_BRANCH: begin
                        if (cond_eval(NIP_REQ.cond, flags_ff)) begin
                            nip_ff    <= align_word(NIP_REQ.target);
                            branch_ff <= 1'b1;
                        end else begin
                            nip_ff <= 16'(nip_ff + crf_pkg::WORD_STEP);
                        end
                    end
                    default: nip_ff <= nip_ff;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign REG_RDATA    = rdata_ff;
    assign ADDR_FULL    = addr_full_ff;
    assign ADDR_WORD    = addr_word_ff;
    assign STACK_PTR    = regs_ff[crf_pkg::STACK_REG_IDX];
    assign STK_BUS      = stk_bus_ff;
    assign POP_DATA     = pop_data_ff;
    assign NIP_OUT      = nip_ff;
    assign FLAGS_OUT    = flags_ff;
    assign RESULT_OUT   = result_ff;
    assign BRANCH_TAKEN = branch_ff;
    assign INT_ACCEPT   = int_accept_ff;
    assign VEC_ADDR     = crf_pkg::RESET_VECTOR_ADDR;
    assign VEC_REQ      = (state_ff == crf_pkg::ST_FETCH_VEC);
    assign CORE_READY   = (state_ff == crf_pkg::ST_RUN);

    ////////////////////////////////////////////////////////////////////////////
    a_reset_mask: assert property (@(posedge CLK) disable iff (RST)
        $fell(RST) |-> FLAGS_OUT[crf_pkg::FLAG_I] && VEC_REQ && !INT_ACCEPT)
        else $error("Mask or vector fetch wrong after reset");

    a_entry_mask: assert property (@(posedge CLK) disable iff (RST)
        INT_ENTRY |=> FLAGS_OUT[crf_pkg::FLAG_I] ##1 !INT_ACCEPT || NMI_PEND || $past(NMI_PEND))
        else $error("Interrupt entry did not set mask");

    a_irq_masked: assert property (@(posedge CLK) disable iff (RST)
        FLAGS_OUT[crf_pkg::FLAG_I] && !NMI_PEND |=> !INT_ACCEPT)
        else $error("Masked interrupt accepted");

    a_nip_even: assert property (@(posedge CLK) disable iff (RST)
        NIP_OUT[0] == 1'b0 && STK_BUS.addr[0] == 1'b0)
        else $error("Odd instruction or stack address");

    a_push_flags: assert property (@(posedge CLK) disable iff (RST)
        STK_REQ.op == crf_pkg::STK_PUSH_FLAGS |=> STK_BUS.we &&
        STK_BUS.wdata == {$past(FLAGS_OUT), $past(FLAGS_OUT)} &&
        STACK_PTR == 16'(align_word($past(STACK_PTR)) - 16'h0002))
        else $error("Flag push not doubled or pointer wrong");

    a_pop_flags: assert property (@(posedge CLK) disable iff (RST)
        STK_REQ.op == crf_pkg::STK_POP_FLAGS && !INT_ENTRY |=>
        FLAGS_OUT == $past(STK_RDATA[15:8]) && !STK_BUS.we)
        else $error("Flag pop not taken from upper byte");

    a_branch_fall: assert property (@(posedge CLK) disable iff (RST)
        running && NIP_REQ.op == crf_pkg::NOP_BRANCH && NIP_REQ.cond == crf_pkg::COND_EQ &&
        !FLAGS_OUT[crf_pkg::FLAG_Z] |=> !BRANCH_TAKEN && NIP_OUT == 16'($past(NIP_OUT) + 16'h0002))
        else $error("Branch taken with condition false");

    a_byte_keep: assert property (@(posedge CLK) disable iff (RST)
        REG_WR.we && !REG_WR.word && !REG_WR.high && REG_WR.sel != 3'h7 |=>
        regs_ff[$past(REG_WR.sel)][15:8] == $past(regs_ff[REG_WR.sel][15:8]))
        else $error("Low byte write disturbed upper byte");

    a_zero_flag: assert property (@(posedge CLK) disable iff (RST)
        FLAG_REQ.op == crf_pkg::FOP_LOGIC && FLAG_REQ.word && STK_REQ.op != crf_pkg::STK_POP_FLAGS
        |=> FLAGS_OUT[crf_pkg::FLAG_Z] == ($past(FLAG_REQ.a) == 16'h0000))
        else $error("Zero flag wrong after logic result");

endmodule

// >>> crf_pkg.sv
package crf_pkg;

    // Condition flag bit positions
    localparam int FLAG_I  = 7;
    localparam int FLAG_U1 = 6;
    localparam int FLAG_H  = 5;
    localparam int FLAG_U0 = 4;
    localparam int FLAG_N  = 3;
    localparam int FLAG_Z  = 2;
    localparam int FLAG_V  = 1;
    localparam int FLAG_C  = 0;

    localparam logic [7:0]  FLAGS_RESET       = 8'h80;
    localparam logic [15:0] REGS_RESET        = 16'h0000;
    localparam logic [15:0] NIP_RESET         = 16'h0000;
    localparam logic [15:0] RESET_VECTOR_ADDR = 16'h0000;
    localparam logic [15:0] WORD_STEP         = 16'h0002;
    localparam logic [2:0]  STACK_REG_IDX     = 3'h7;
    localparam logic [3:0]  NIBBLE_MAX        = 4'h9;
    localparam logic [3:0]  DEC_ADJ           = 4'h6;

    typedef enum logic [3:0] {
        FOP_NONE       = 4'h0,
        FOP_ADD        = 4'h1,
        FOP_ADDX       = 4'h2,
        FOP_SUB        = 4'h3,
        FOP_SUBX       = 4'h4,
        FOP_CMP        = 4'h5,
        FOP_NEG        = 4'h6,
        FOP_LOGIC      = 4'h7,
        FOP_SHIFT      = 4'h8,
        FOP_BIT_ACC    = 4'h9,
        FOP_LOAD_FLAGS = 4'hA,
        FOP_AND_FLAGS  = 4'hB,
        FOP_OR_FLAGS   = 4'hC,
        FOP_XOR_FLAGS  = 4'hD,
        FOP_DEC_ADD    = 4'hE,
        FOP_DEC_SUB    = 4'hF
    } crf_fop_e;

    typedef enum logic [2:0] {
        STK_NONE       = 3'h0,
        STK_PUSH_WORD  = 3'h1,
        STK_PUSH_FLAGS = 3'h2,
        STK_POP_WORD   = 3'h3,
        STK_POP_FLAGS  = 3'h4
    } crf_stk_e;

    typedef enum logic [1:0] {
        NOP_HOLD    = 2'h0,
        NOP_ADVANCE = 2'h1,
        NOP_JUMP    = 2'h2,
        NOP_BRANCH  = 2'h3
    } crf_nip_e;

    typedef enum logic [3:0] {
        COND_ALWAYS = 4'h0, COND_NEVER = 4'h1, COND_HI = 4'h2, COND_LS = 4'h3,
        COND_CC     = 4'h4, COND_CS    = 4'h5, COND_NE = 4'h6, COND_EQ = 4'h7,
        COND_VC     = 4'h8, COND_VS    = 4'h9, COND_PL = 4'hA, COND_MI = 4'hB,
        COND_GE     = 4'hC, COND_LT    = 4'hD, COND_GT = 4'hE, COND_LE = 4'hF
    } crf_cond_e;

    typedef enum logic [1:0] {
        ST_FETCH_VEC = 2'b01,
        ST_RUN       = 2'b10
    } crf_state_e;

    typedef struct packed {
        logic        we;
        logic [2:0]  sel;
        logic        word;
        logic        high;
        logic [15:0] data;
    } crf_reg_wr_s;

    typedef struct packed {
        logic [2:0] sel;
        logic       word;
        logic       high;
    } crf_reg_rd_s;

    typedef struct packed {
        crf_fop_e    op;
        logic        word;
        logic [15:0] a;
        logic [15:0] b;
        logic        bit_in;
    } crf_flag_req_s;

    typedef struct packed {
        crf_stk_e    op;
        logic [15:0] wdata;
    } crf_stk_req_s;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        we;
    } crf_stk_bus_s;

    typedef struct packed {
        crf_nip_e    op;
        crf_cond_e   cond;
        logic [15:0] target;
    } crf_nip_req_s;

endpackage

// >>> crf_mem_model.sv
`timescale 1ns/1ps
module crf_mem_model (
    input  wire logic                  CLK,
    input  wire logic                  RST,
    input  wire crf_pkg::crf_stk_bus_s BUS,
    input  wire logic                  VEC_REQ,
    output logic [15:0]                RDATA,
    output logic [15:0]                VEC_DATA,
    output logic                       VEC_VALID
);
    logic [15:0] mem [0:255];
    logic [3:0]  dly_ff;
    // Whole words only, address bit zero unused
    always_ff @(posedge CLK) begin
        if (BUS.we) begin
            mem[BUS.addr[8:1]] <= BUS.wdata;
        end
    end
    // Bypass so a pop right after a push sees the new word
    assign RDATA = BUS.we ? BUS.wdata : mem[BUS.addr[8:1]];
    // Slow vector answer; odd word tests alignment
    always_ff @(posedge CLK) begin
        dly_ff <= (RST || !VEC_REQ) ? 4'h0 : dly_ff + 4'h1;
    end
    assign VEC_VALID = VEC_REQ && dly_ff == 4'hF;
    assign VEC_DATA  = VEC_VALID ? 16'h0201 : 16'hFDFE;
endmodule

// >>> cpu_registers_and_flags_test.sv
`timescale 1ns/1ps
module cpu_registers_and_flags_test;
    typedef struct {int due; int sel; logic [15:0] val;} crf_note_s;
    crf_note_s q[$];
    crf_note_s n;
    logic clk = 0, rst = 1, irq = 1, ient = 0, nmi = 0, acc, brt, vrq, vv, rdy;
    crf_pkg::crf_reg_wr_s wr = '0;
    crf_pkg::crf_reg_rd_s rd = '0;
    crf_pkg::crf_flag_req_s fr = '0;
    crf_pkg::crf_stk_req_s sr = '0;
    crf_pkg::crf_nip_req_s nr = '0;
    crf_pkg::crf_stk_bus_s bus;
    logic [2:0] asel = 3'h0;
    logic [7:0] flags;
    logic [15:0] rdata, aword, afull, pd, sp, nip, res, srd, vd, v;
    logic [31:0] seed = 32'h42e5e51e;
    int cyc = 0, miscompares = 0, cmp_count = 0, i;
    string nm[11] = '{"rdata", "aword", "flags", "nip", "sp", "wdata", "res", "acc",
                      "taken", "afull", "pop"};
    crf_core_regs uut (.CLK(clk), .RST(rst), .REG_WR(wr), .REG_RD(rd), .ADDR_SEL(asel),
        .FLAG_REQ(fr), .STK_REQ(sr), .STK_RDATA(srd), .NIP_REQ(nr), .IRQ_PEND(irq),
        .NMI_PEND(nmi), .INT_ENTRY(ient), .VEC_DATA(vd), .VEC_VALID(vv), .REG_RDATA(rdata),
        .ADDR_FULL(afull), .ADDR_WORD(aword), .STACK_PTR(sp), .STK_BUS(bus), .POP_DATA(pd),
        .NIP_OUT(nip), .FLAGS_OUT(flags), .RESULT_OUT(res), .BRANCH_TAKEN(brt),
        .INT_ACCEPT(acc), .VEC_ADDR(), .VEC_REQ(vrq), .CORE_READY(rdy));
    crf_mem_model mem (.CLK(clk), .RST(rst), .BUS(bus), .VEC_REQ(vrq), .RDATA(srd),
        .VEC_DATA(vd), .VEC_VALID(vv));
    initial begin
        forever #50 clk = ~clk;
    end
    always @(posedge clk) cyc++;
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [15:0] pick(int s);
        case (s)
            0: return rdata;
            1: return aword;
            2: return {8'h00, flags};
            3: return nip;
            4: return sp;
            5: return bus.wdata;
            6: return res;
            7: return {15'h0000, acc};
            8: return {15'h0000, brt};
            9: return afull;
            default: return pd;
        endcase
    endfunction
    task automatic check(int s, logic [15:0] seen, logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm[s], exp, seen);
        end
    endtask
    task automatic ex(int s, int d, logic [15:0] e);
        q.push_back('{cyc + d, s, e});
    endtask
    task automatic fl(crf_pkg::crf_fop_e op, logic w, logic [15:0] a, b, logic bi, logic [15:0] e);
        @(negedge clk);
        fr = '{op, w, a, b, bi};
        ex(2, 1, e);
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(negedge clk) begin
        while (q.size() > 0 && q[0].due <= cyc) begin
            n = q.pop_front();
            check(n.sel, pick(n.sel), n.val);
        end
    end
    initial begin
        #40000;
        miscompares++;
        end_sim();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(negedge clk);
        rst = 0;
        ex(2, 0, 16'h0080);
        ex(7, 0, 16'h0000);
        for (i = 0; i < 100 && rdy !== 1'b1; i++) @(negedge clk);
        ex(3, 0, 16'h0200);
        seed = lfsr(seed);
        v = seed[15:0];
        wr = '{1'b1, 3'h2, 1'b1, 1'b0, v};
        @(negedge clk);
        wr = '{1'b1, 3'h2, 1'b0, 1'b1, 16'h00A5};
        rd = '{3'h2, 1'b1, 1'b0};
        ex(0, 1, v);
        @(negedge clk);
        wr = '{1'b1, 3'h2, 1'b0, 1'b0, 16'h003D};
        ex(0, 1, {8'hA5, v[7:0]});
        @(negedge clk);
        wr = '{1'b1, 3'h7, 1'b1, 1'b0, 16'h1001};
        asel = 3'h2;
        ex(0, 1, 16'hA53D);
        ex(1, 1, 16'hA53C);
        ex(9, 1, 16'hA53D);
        @(negedge clk);
        wr.we = 0;
        rd = '{3'h2, 1'b0, 1'b1};
        sr = '{crf_pkg::STK_PUSH_WORD, 16'hA55A};
        ex(0, 1, 16'h00A5);
        ex(4, 1, 16'h0FFE);
        @(negedge clk);
        sr = '{crf_pkg::STK_POP_FLAGS, 16'h0000};
        ex(2, 1, 16'h00A5);
        ex(4, 1, 16'h1000);
        @(negedge clk);
        sr = '{crf_pkg::STK_PUSH_FLAGS, 16'h0000};
        ex(5, 1, 16'hA5A5);
        @(negedge clk);
        sr = '{crf_pkg::STK_POP_WORD, 16'h0000};
        ex(10, 1, 16'hA5A5);
        ex(4, 1, 16'h1000);
        @(negedge clk);
        sr = '0;
        fl(crf_pkg::FOP_LOAD_FLAGS, 0, 0, 16'h0080, 0, 16'h0080);
        fl(crf_pkg::FOP_ADD, 0, 16'h000F, 16'h0001, 0, 16'h00A0);
        fl(crf_pkg::FOP_SUB, 1, 16'h8000, 16'h0001, 0, 16'h00A2);
        fl(crf_pkg::FOP_ADD, 0, 16'h00FF, 16'h0001, 0, 16'h00A5);
        fl(crf_pkg::FOP_LOAD_FLAGS, 0, 0, 16'h0050, 0, 16'h0050);
        fl(crf_pkg::FOP_OR_FLAGS, 0, 0, 16'h000F, 0, 16'h005F);
        fl(crf_pkg::FOP_AND_FLAGS, 0, 0, 16'h00EF, 0, 16'h004F);
        fl(crf_pkg::FOP_XOR_FLAGS, 0, 0, 16'h00C0, 0, 16'h008F);
        fl(crf_pkg::FOP_LOGIC, 1, 16'h0000, 0, 0, 16'h0085);
        fl(crf_pkg::FOP_SHIFT, 0, 16'h0080, 0, 0, 16'h0088);
        fl(crf_pkg::FOP_BIT_ACC, 0, 0, 0, 1, 16'h0089);
        @(negedge clk);
        fr = '0;
        nr = '{crf_pkg::NOP_BRANCH, crf_pkg::COND_CS, 16'h0333};
        ex(3, 1, 16'h0332);
        ex(8, 1, 16'h0001);
        @(negedge clk);
        nr.cond = crf_pkg::COND_EQ;
        ex(3, 1, 16'h0334);
        ex(8, 1, 16'h0000);
        @(negedge clk);
        nr = '0;
        fl(crf_pkg::FOP_LOAD_FLAGS, 0, 0, 0, 0, 16'h0000);
        ex(7, 2, 16'h0001);
        @(negedge clk);
        fr = '{crf_pkg::FOP_DEC_ADD, 1'b0, 16'h000A, 16'h0000, 1'b0};
        ex(6, 1, 16'h0010);
        fl(crf_pkg::FOP_LOAD_FLAGS, 0, 0, 0, 0, 16'h0080);
        ient = 1;
        ex(7, 2, 16'h0000);
        @(negedge clk);
        ient = 0;
        fr = '0;
        @(negedge clk);
        nmi = 1;
        ex(7, 2, 16'h0001);
        repeat (4) @(negedge clk);
        end_sim();
    end
endmodule
